// >>> cxe_pkg.sv
package cxe_pkg;

   // -------------------------------------------------------------
   // flag image layout
   // -------------------------------------------------------------
   localparam logic [15:0] FLAG_TF_MASK = 16'h0100;
   localparam logic [15:0] FLAG_TF_CLR  = 16'hFEFF;
   localparam logic [15:0] FLAG_IF_MASK = 16'h0200;
   localparam logic [15:0] FLAG_IF_CLR  = 16'hFDFF;
   localparam logic [15:0] FLAG_OF_MASK = 16'h0800;

   // -------------------------------------------------------------
   // values after reset
   // -------------------------------------------------------------
   localparam logic [15:0] RESET_FLAGS = 16'h0000;
   localparam logic [15:0] RESET_IP    = 16'h0000;
   localparam logic [15:0] RESET_CS    = 16'hFFFF;
   localparam logic [15:0] RESET_SEG   = 16'h0000;
   localparam logic [15:0] RESET_SP    = 16'h0000;
   localparam logic [19:0] RESET_FETCH = 20'hF_FFF0;

   // -------------------------------------------------------------
   // vector types, opcodes, stack and table geometry
   // -------------------------------------------------------------
   localparam logic [7:0]  TYPE_DIVERR    = 8'h00;
   localparam logic [7:0]  TYPE_STEP      = 8'h01;
   localparam logic [7:0]  TYPE_NMI       = 8'h02;
   localparam logic [7:0]  TYPE_BREAK     = 8'h03;
   localparam logic [7:0]  TYPE_OVERFLOW  = 8'h04;
   localparam logic [7:0]  OPC_BREAKPOINT = 8'hCC;
   localparam logic [15:0] STACK_STEP     = 16'h0002;
   localparam logic [19:0] VEC_ENTRY_SIZE = 20'h0_0004;
   localparam logic [1:0]  WORDS_LAST     = 2'h2;

   // -------------------------------------------------------------
   // wishbone register offsets (byte addresses)
   // -------------------------------------------------------------
   localparam logic [5:0] ADR_FLAGS  = 6'h00;
   localparam logic [5:0] ADR_CSIP   = 6'h04;
   localparam logic [5:0] ADR_DSES   = 6'h08;
   localparam logic [5:0] ADR_SSSP   = 6'h0C;
   localparam logic [5:0] ADR_STATUS = 6'h10;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      K_PLAIN, K_STI, K_CLI, K_INTERRUPT_RETURN_INSTRUCTION, K_HLT, K_INTN, K_INTO, K_DIVERR
   } cxe_kind_e;

   typedef enum logic [5:0] {
      ST_RUN  = 6'b000001,
      ST_PUSH = 6'b000010,
      ST_VEC  = 6'b000100,
      ST_POP  = 6'b001000,
      ST_INTA = 6'b010000,
      ST_HALT = 6'b100000
   } cxe_state_e;

   typedef struct packed {
      logic        done;
      cxe_kind_e   kind;
      logic [7:0]  opcode;
      logic [7:0]  vtype;
      logic [15:0] next_ip;
   } cxe_instr_s;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [19:0] addr;
      logic [15:0] wdata;
   } cxe_mem_req_s;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } cxe_mem_rsp_s;

   typedef struct packed {
      cxe_state_e  st;
      logic [15:0] flags;
      logic [15:0] cs;
      logic [15:0] ip;
      logic [15:0] ds;
      logic [15:0] ss;
      logic [15:0] es;
      logic [15:0] sp;
      logic [15:0] tmp;
      logic [7:0]  vtype;
      logic [1:0]  cnt;
      logic        step_after;
      logic        shadow;
      logic        nmi_pend;
      logic        nmi_prev;
      logic        flush;
      logic        inta;
      logic        mreq;
      logic        mwe;
      logic [19:0] maddr;
      logic [15:0] mwdata;
      logic [19:0] faddr;
      logic        ack;
      logic [31:0] rdat;
   } cxe_state_s;

   localparam cxe_state_s STATE_RESET = '{
      st: ST_RUN, flags: RESET_FLAGS, cs: RESET_CS, ip: RESET_IP,
      ds: RESET_SEG, ss: RESET_SEG, es: RESET_SEG, sp: RESET_SP,
      faddr: RESET_FETCH, flush: 1'b1, default: '0};

   // segment:offset to 20-bit physical address
   function automatic logic [19:0] phys(input logic [15:0] seg,
                                        input logic [15:0] off);
      return {seg, 4'h0} + {4'h0, off};
   endfunction

endpackage

// >>> cxe_unit.sv
`timescale 1ns/100ps
// Contract
// - entry pushes flags, cs, ip; clears tf, if
// - maskable blocked until instruction after sti
// - nmi accepted inside handlers, ignoring if
// - internal interrupts taken inside handlers too
// - return pops ip, cs, flags in order
// - tf set: type 1 after each instruction
// - step handler runs tf clear; return restores
// - tf only via flag image, masks 0100/feff
// - first trap after instruction following return
// - other interrupt vectored, then step trap
// - type 3 breakpoint from one-byte cc opcode
// - reset stops activity, initialises on release
// - reset values: flags, ip, segments, queue
// - first fetch from physical ffff0 after reset
// - reset leaves maskable interrupts disabled
// - halt stops until interrupt or reset
// - no outputs float while halted
// - bus hold granted while halted as usual
// - vector found at type times four
// - nmi uses fixed type 2, no acknowledge
// - internal interrupt other than single step beats pending external ones
module cxe_unit
   import cxe_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [5:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output      logic [31:0]  wb_dat_o,
   output      logic         wb_ack_o,
   input  wire cxe_instr_s   instr_i,
   output      logic         run_o,
   output      logic         queue_flush_o,
   output      logic [15:0]  fetch_cs_o,
   output      logic [15:0]  fetch_ip_o,
   output      logic [19:0]  fetch_addr_o,
   output      logic [15:0]  flags_o,
   output      cxe_mem_req_s mem_req_o,
   input  wire cxe_mem_rsp_s mem_rsp_i,
   input  wire logic         maskable_request_line_i,
   input  wire logic         nmi_i,
   output      logic         inta_o,
   input  wire logic         inta_ack_i,
   input  wire logic [7:0]   inta_type_i,
   input  wire logic         hold_i,
   output      logic         hlda_o,
   output      logic         halted_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cxe_state_s s_reg;
   cxe_state_s s_next;
   logic       nmi_rise;
   logic       nmi_any;
   logic       maskable_request_line_ok;

   // byte-lane merge for wishbone writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // arm an interrupt entry; step_after remembers tf for a re-trap
   function automatic cxe_state_s start_entry(input cxe_state_s s,
                                              input logic [7:0] t);
      cxe_state_s r;
      r            = s;
      r.st         = ST_PUSH;
      r.cnt        = 2'h0;
      r.mreq       = 1'b0;
      r.vtype      = t;
      r.step_after = ((s.flags & FLAG_TF_MASK) != 16'h0000) &&
                     (t != TYPE_STEP);
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.flush    = 1'b0;
      s_next.ack      = 1'b0;
      s_next.nmi_prev = nmi_i;
      nmi_rise        = nmi_i & ~s_reg.nmi_prev;
      nmi_any         = s_reg.nmi_pend | nmi_rise;
      // a new edge during the take survives
      s_next.nmi_pend = nmi_any;
      maskable_request_line_ok         = 1'b0;

      // register access first, so a same-cycle hardware update wins
      if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
         s_next.ack  = 1'b1;
         s_next.rdat = 32'h0000_0000;
         case (wb_adr_i)
            ADR_FLAGS: begin
               s_next.rdat = {16'h0000, s_reg.flags};
               if (wb_we_i) begin
                  // tf is changed only through this image
                  s_next.flags = 16'(merge({16'h0000, s_reg.flags}, wb_dat_i,
                                           {2'b00, wb_sel_i[1:0]}));
               end
            end
            ADR_CSIP: begin
               s_next.rdat = {s_reg.cs, s_reg.ip};
            end
            ADR_DSES: begin
               s_next.rdat = {s_reg.es, s_reg.ds};
               if (wb_we_i) begin
                  {s_next.es, s_next.ds} = merge({s_reg.es, s_reg.ds},
                                                 wb_dat_i, wb_sel_i);
               end
            end
            ADR_SSSP: begin
               s_next.rdat = {s_reg.ss, s_reg.sp};
               if (wb_we_i) begin
                  {s_next.ss, s_next.sp} = merge({s_reg.ss, s_reg.sp},
                                                 wb_dat_i, wb_sel_i);
               end
            end
            ADR_STATUS: begin
               s_next.rdat = {13'h0000, s_reg.nmi_pend, s_reg.shadow,
                              s_reg.step_after, s_reg.vtype, 2'b00,
                              s_reg.st};
            end
            default: begin
               s_next.rdat = 32'h0000_0000;
            end
         endcase
      end

      case (s_reg.st)
         // instruction boundary decisions
         ST_RUN: begin
            if (instr_i.done) begin
               s_next.ip     = instr_i.next_ip;
               s_next.shadow = (instr_i.kind == K_STI);
               if (instr_i.kind == K_STI) begin
                  s_next.flags = s_next.flags | FLAG_IF_MASK;
               end
               if (instr_i.kind == K_CLI) begin
                  s_next.flags = s_next.flags & FLAG_IF_CLR;
               end
               // held off at the sti boundary itself, open one later
               maskable_request_line_ok = maskable_request_line_i && !s_next.shadow &&
                         ((s_next.flags & FLAG_IF_MASK) != 16'h0000);
               // internal first, then nmi, maskable_request_line, single step
               if (instr_i.kind == K_INTERRUPT_RETURN_INSTRUCTION) begin
                  s_next.st   = ST_POP;
                  s_next.cnt  = 2'h0;
                  s_next.mreq = 1'b0;
               end else if (instr_i.kind == K_DIVERR) begin
                  s_next = start_entry(s_next, TYPE_DIVERR);
               end else if (instr_i.kind == K_INTN) begin
                  s_next = start_entry(s_next,
                     (instr_i.opcode == OPC_BREAKPOINT) ?
                     TYPE_BREAK : instr_i.vtype);
               end else if (instr_i.kind == K_INTO &&
                            (s_reg.flags & FLAG_OF_MASK) != 16'h0000) begin
                  s_next = start_entry(s_next, TYPE_OVERFLOW);
               end else if (instr_i.kind == K_HLT) begin
                  s_next.st = ST_HALT;
               end else if (nmi_any) begin
                  s_next          = start_entry(s_next, TYPE_NMI);
                  s_next.nmi_pend = s_reg.nmi_pend & nmi_rise;
               end else if (maskable_request_line_ok) begin
                  s_next.st   = ST_INTA;
                  s_next.inta = 1'b1;
               end else if ((s_reg.flags & FLAG_TF_MASK) != 16'h0000) begin
                  // tf set by a return is seen here only after the
                  // next instruction completes
                  s_next = start_entry(s_next, TYPE_STEP);
               end
            end
         end
         // push flags, cs, ip below ss:sp
         ST_PUSH: begin
            if (!s_reg.mreq) begin
               s_next.sp     = s_reg.sp - STACK_STEP;
               s_next.mreq   = 1'b1;
               s_next.mwe    = 1'b1;
               s_next.maddr  = phys(s_reg.ss, s_reg.sp - STACK_STEP);
               s_next.mwdata = (s_reg.cnt == 2'h0) ? s_reg.flags :
                               (s_reg.cnt == 2'h1) ? s_reg.cs : s_reg.ip;
            end else if (mem_rsp_i.ack) begin
               s_next.mreq = 1'b0;
               s_next.cnt  = s_reg.cnt + 2'h1;
               if (s_reg.cnt == WORDS_LAST) begin
                  s_next.st    = ST_VEC;
                  s_next.cnt   = 2'h0;
                  // handler runs unstepped, masked
                  s_next.flags = s_reg.flags & FLAG_TF_CLR &
                                 FLAG_IF_CLR;
               end
            end
         end
         // offset word then segment word of the table entry
         ST_VEC: begin
            if (!s_reg.mreq) begin
               s_next.mreq  = 1'b1;
               s_next.mwe   = 1'b0;
               s_next.maddr = 20'(s_reg.vtype) * VEC_ENTRY_SIZE +
                              {17'h0_0000, s_reg.cnt, 1'b0};
            end else if (mem_rsp_i.ack) begin
               s_next.mreq = 1'b0;
               if (s_reg.cnt == 2'h0) begin
                  s_next.tmp = mem_rsp_i.rdata;
                  s_next.cnt = 2'h1;
               end else begin
                  s_next.ip    = s_reg.tmp;
                  s_next.cs    = mem_rsp_i.rdata;
                  s_next.flush = 1'b1;
                  s_next.cnt   = 2'h0;
                  s_next.st    = ST_RUN;
                  // re-check before the handler's first instruction
                  if (nmi_any) begin
                     s_next          = start_entry(s_next, TYPE_NMI);
                     s_next.nmi_pend = s_reg.nmi_pend & nmi_rise;
                  end else if (s_reg.step_after) begin
                     s_next = start_entry(s_next, TYPE_STEP);
                  end
               end
            end
         end
         // pop ip, cs, flags from ss:sp
         ST_POP: begin
            if (!s_reg.mreq) begin
               s_next.mreq  = 1'b1;
               s_next.mwe   = 1'b0;
               s_next.maddr = phys(s_reg.ss, s_reg.sp);
            end else if (mem_rsp_i.ack) begin
               s_next.mreq = 1'b0;
               s_next.sp   = s_reg.sp + STACK_STEP;
               s_next.cnt  = s_reg.cnt + 2'h1;
               case (s_reg.cnt)
                  2'h0:    s_next.ip    = mem_rsp_i.rdata;
                  2'h1:    s_next.cs    = mem_rsp_i.rdata;
                  default: s_next.flags = mem_rsp_i.rdata;
               endcase
               if (s_reg.cnt == WORDS_LAST) begin
                  s_next.st     = ST_RUN;
                  s_next.cnt    = 2'h0;
                  s_next.flush  = 1'b1;
                  s_next.shadow = 1'b1;
               end
            end
         end
         // controller supplies the type; nmi never comes here
         ST_INTA: begin
            if (inta_ack_i) begin
               s_next.inta = 1'b0;
               s_next      = start_entry(s_next, inta_type_i);
            end
         end
         ST_HALT: begin
            if (nmi_any) begin
               s_next          = start_entry(s_next, TYPE_NMI);
               s_next.nmi_pend = s_reg.nmi_pend & nmi_rise;
            end else if (maskable_request_line_i &&
                         (s_reg.flags & FLAG_IF_MASK) != 16'h0000) begin
               s_next.st   = ST_INTA;
               s_next.inta = 1'b1;
            end
         end
         default: begin
            s_next.st = ST_RUN;
         end
      endcase
      s_next.faddr = phys(s_next.cs, s_next.ip);
   end

   // reset holds every field at its initial value while high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output stays driven, halted or not
   assign mem_req_o     = '{req: s_reg.mreq, we: s_reg.mwe,
                            addr: s_reg.maddr,
                            wdata: s_reg.mwdata};
   assign wb_dat_o      = s_reg.rdat;
   assign wb_ack_o      = s_reg.ack;
   assign fetch_cs_o    = s_reg.cs;
   assign fetch_ip_o    = s_reg.ip;
   assign fetch_addr_o  = s_reg.faddr;
   assign flags_o       = s_reg.flags;
   assign queue_flush_o = s_reg.flush;
   assign inta_o        = s_reg.inta;
   assign halted_o      = (s_reg.st == ST_HALT);
   assign run_o         = (s_reg.st == ST_RUN) && !rst_i && !hold_i;
   // hold only between sequences, never during acknowledge
   assign hlda_o        = hold_i && !s_reg.mreq && !rst_i &&
                          (s_reg.st == ST_RUN ||
                           s_reg.st == ST_HALT);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_entry_clears;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_VEC |-> (s_reg.flags & (FLAG_TF_MASK | FLAG_IF_MASK))
                             == 16'h0000;
   endproperty
   a_entry_clears: assert property (p_entry_clears)
      else $error("handler entered with tf or if set");

   property p_sti_shadow;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_RUN && instr_i.done && instr_i.kind == K_STI
      |=> s_reg.st != ST_INTA;
   endproperty
   a_sti_shadow: assert property (p_sti_shadow)
      else $error("maskable taken right after sti");

   property p_halt_nmi;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_HALT && nmi_any
      |=> s_reg.st == ST_PUSH && s_reg.vtype == TYPE_NMI && !inta_o;
   endproperty
   a_halt_nmi: assert property (p_halt_nmi)
      else $error("nmi did not end halt with type 2");

   property p_ret_shadow;
      @(posedge clk_i) disable iff (rst_i)
      $past(s_reg.st) == ST_POP && s_reg.st == ST_RUN
      |-> s_reg.shadow && queue_flush_o;
   endproperty
   a_ret_shadow: assert property (p_ret_shadow)
      else $error("return did not flush and shadow");

   property p_reset_vals;
      @(posedge clk_i)
      $past(rst_i) |-> fetch_addr_o == RESET_FETCH && s_reg.cs == RESET_CS
                   && s_reg.ds == RESET_SEG && queue_flush_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("bad state after reset");

   property p_reset_if;
      @(posedge clk_i)
      $past(rst_i) |-> (flags_o & FLAG_IF_MASK) == 16'h0000 && !inta_o;
   endproperty
   a_reset_if: assert property (p_reset_if)
      else $error("maskable enabled after reset");

   property p_halt_stays;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_HALT && !nmi_any && !maskable_request_line_i
      |=> halted_o && !run_o;
   endproperty
   a_halt_stays: assert property (p_halt_stays)
      else $error("halt left without cause");

   property p_halt_hold;
      @(posedge clk_i) disable iff (rst_i)
      halted_o && hold_i |-> hlda_o;
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("hold not granted in halt");

   property p_vec_addr;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_VEC && s_reg.mreq && s_reg.cnt == 2'h0
      |-> s_reg.maddr == {10'h000, s_reg.vtype, 2'b00} && !s_reg.mwe;
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector address not type times four");

   property p_step_trap;
      @(posedge clk_i) disable iff (rst_i)
      s_reg.st == ST_RUN && instr_i.done && instr_i.kind == K_PLAIN &&
      (flags_o & FLAG_TF_MASK) != 16'h0000 && !nmi_any &&
      !maskable_request_line_i
      |=> s_reg.st == ST_PUSH && s_reg.vtype == TYPE_STEP;
   endproperty
   a_step_trap: assert property (p_step_trap)
      else $error("no single-step trap");

endmodule

// >>> cxe_far_model.sv
`timescale 1ns/100ps
module cxe_far_model
   import cxe_pkg::*;
#(
   parameter logic [7:0] INTA_TYPE = 8'h40
)(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [1:0]   slow_i,
   input  wire cxe_mem_req_s mem_req_i,
   output      cxe_mem_rsp_s mem_rsp_o,
   input  wire logic         inta_i,
   output      logic         inta_ack_o,
   output      logic [7:0]   inta_type_o
);
   logic [15:0] mem [logic [19:0]];
   logic [1:0]  wait_q;

   // vector table: type t points at 2000:1000+t
   initial begin
      for (int t = 0; t < 256; t++) begin
         mem[20'(t * 4)]     = 16'h1000 + 16'(t);
         mem[20'(t * 4 + 2)] = 16'h2000;
      end
   end

   // answer after slow_i cycles; idle data toggles so stale reads show
   always @(posedge clk_i) begin
      if (rst_i) begin
         mem_rsp_o   <= '0;
         inta_ack_o  <= 1'b0;
         inta_type_o <= 8'h00;
         wait_q      <= 2'h0;
      end else begin
         mem_rsp_o.ack   <= 1'b0;
         inta_ack_o      <= 1'b0;
         mem_rsp_o.rdata <= ~mem_rsp_o.rdata;
         inta_type_o     <= ~inta_type_o;
         if ((mem_req_i.req || inta_i) && !mem_rsp_o.ack && !inta_ack_o) begin
            if (wait_q < slow_i) begin
               wait_q <= wait_q + 2'h1;
            end else if (inta_i) begin
               wait_q      <= 2'h0;
               inta_ack_o  <= 1'b1;
               inta_type_o <= INTA_TYPE;
            end else begin
               wait_q        <= 2'h0;
               mem_rsp_o.ack <= 1'b1;
               if (mem_req_i.we)
                  mem[mem_req_i.addr] = mem_req_i.wdata;
               else
                  mem_rsp_o.rdata <= mem[mem_req_i.addr];
            end
         end
      end
   end
endmodule

// >>> tb.sv
`timescale 1ns/100ps
module tb
   import cxe_pkg::*;
;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         cyc   = 1'b0;
   logic         we    = 1'b0;
   logic [5:0]   adr   = 6'h00;
   logic [31:0]  wdat  = 32'h0000_0000;
   logic [31:0]  rdat, q;
   logic         ack, run, flush, inta, inta_ack, hlda, halted;
   logic [15:0]  fcs, fip, flags;
   logic [19:0]  faddr;
   logic [7:0]   inta_type;
   cxe_instr_s   ins   = '0;
   cxe_mem_req_s mreq;
   cxe_mem_rsp_s mrsp;
   logic         maskable_request_line  = 1'b0;
   logic         nmi   = 1'b0;
   logic         hold  = 1'b0;
   logic [1:0]   slow  = 2'h0;
   int           mismatches = 0;
   int           num_checks = 0;

   cxe_unit u_cxe_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_i(ins),
      .run_o(run), .queue_flush_o(flush), .fetch_cs_o(fcs),
      .fetch_ip_o(fip), .fetch_addr_o(faddr), .flags_o(flags),
      .mem_req_o(mreq), .mem_rsp_i(mrsp), .maskable_request_line_i(maskable_request_line),
      .nmi_i(nmi), .inta_o(inta), .inta_ack_i(inta_ack),
      .inta_type_i(inta_type), .hold_i(hold), .hlda_o(hlda),
      .halted_o(halted));

   cxe_far_model u_cxe_far_model (.clk_i(clk_i), .rst_i(rst_i),
      .slow_i(slow), .mem_req_i(mreq), .mem_rsp_o(mrsp), .inta_i(inta),
      .inta_ack_o(inta_ack), .inta_type_o(inta_type));

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask

   // classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
   endtask

   // one finished instruction, only while the unit may run
   task automatic step(input cxe_kind_e k, input logic [7:0] op,
                       input logic [7:0] vt, input logic [15:0] nip);
      int n = 0;
      @(posedge clk_i);
      while (run !== 1'b1 && n++ < 200) @(posedge clk_i);
      ins <= '{1'b1, k, op, vt, nip};
      @(posedge clk_i);
      ins.done <= 1'b0;
   endtask

   task automatic wflush(input logic [15:0] ip, input string s);
      int n = 0;
      do @(posedge clk_i); while (flush !== 1'b1 && n++ < 300);
      check({flush, fcs, fip}, {1'b1, 16'h2000, ip});
      $display("test %s done", s);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog: the sequence needs a few hundred cycles
   initial begin
      #60000;
      mismatches++;
      conclude();
   end

   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      check({run, flush, fcs, fip, flags}, {2'b01, 48'hFFFF_0000_0000});
      check(faddr, 20'hF_FFF0);
      rst_i <= 1'b0;
      wb(1'b0, ADR_DSES, 32'h0);
      check(q, 32'h0);
      wb(1'b1, ADR_SSSP, 32'h0000_8000);
      wb(1'b0, ADR_SSSP, 32'h0);
      check(q, 32'h0000_8000);
      wb(1'b0, 6'h3C, 32'h0);
      check(q, 32'h0);
      maskable_request_line <= 1'b1;
      step(K_PLAIN, 8'h90, 8'h00, 16'h0002);
      repeat (4) @(posedge clk_i);
      check(inta, 1'b0);
      maskable_request_line <= 1'b0;
      step(K_INTN, 8'hCD, 8'h21, 16'h0010);
      wflush(16'h1021, "entry");
      check(flags & 16'h0300, 16'h0);
      check({u_cxe_far_model.mem[20'h07FFE], u_cxe_far_model.mem[20'h07FFC],
             u_cxe_far_model.mem[20'h07FFA]}, 48'h0000_FFFF_0010);
      step(K_INTN, OPC_BREAKPOINT, 8'h55, 16'h0005);
      wflush(16'h1003, "breakpoint");
      slow <= 2'h2;
      step(K_DIVERR, 8'hF6, 8'h00, 16'h0007);
      wflush(16'h1000, "divide");
      step(K_DIVERR, 8'hF6, 8'h00, 16'h0009);
      wflush(16'h1000, "reentry");
      check(u_cxe_far_model.mem[20'h07FE8], 16'h0009);
      step(K_INTERRUPT_RETURN_INSTRUCTION, 8'hCF, 8'h00, 16'h0000);
      wflush(16'h0009, "return");
      nmi <= 1'b1;
      @(posedge clk_i);
      nmi <= 1'b0;
      step(K_PLAIN, 8'h90, 8'h00, 16'h000B);
      wflush(16'h1002, "nmi");
      check(inta, 1'b0);
      maskable_request_line <= 1'b1;
      step(K_STI, 8'hFB, 8'h00, 16'h000D);
      repeat (3) @(posedge clk_i);
      check({inta, run}, 2'b01);
      step(K_PLAIN, 8'h90, 8'h00, 16'h000F);
      wflush(16'h1040, "sti");
      maskable_request_line <= 1'b0;
      wb(1'b1, ADR_FLAGS, 32'h0000_0100);
      step(K_PLAIN, 8'h90, 8'h00, 16'h0011);
      wflush(16'h1001, "trap");
      check(flags & FLAG_TF_MASK, 16'h0);
      check(u_cxe_far_model.mem[20'h07FE0], 16'h0100);
      step(K_INTERRUPT_RETURN_INSTRUCTION, 8'hCF, 8'h00, 16'h0000);
      wflush(16'h0011, "trap return");
      check(flags & FLAG_TF_MASK, 16'h0100);
      step(K_PLAIN, 8'h90, 8'h00, 16'h0013);
      wflush(16'h1001, "trap again");
      wb(1'b1, ADR_FLAGS, 32'h0000_0100);
      step(K_INTN, 8'hCD, 8'h21, 16'h0017);
      wflush(16'h1021, "int while stepping");
      wflush(16'h1001, "step before handler");
      check(u_cxe_far_model.mem[20'h07FD0], 16'h1021);
      step(K_HLT, 8'hF4, 8'h00, 16'h0015);
      hold <= 1'b1;
      repeat (4) @(posedge clk_i);
      check({halted, hlda}, 2'b11);
      hold <= 1'b0;
      maskable_request_line <= 1'b1;
      repeat (4) @(posedge clk_i);
      check(halted, 1'b1);
      nmi  <= 1'b1;
      @(posedge clk_i);
      nmi  <= 1'b0;
      wflush(16'h1002, "halt");
      maskable_request_line  <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({run, fcs, fip}, {1'b0, 32'hFFFF_0000});
      $display("test reset done");
      conclude();
   end
endmodule
